// [hdl/bsm_pkg.sv]
// Package: boot strap mode decoder constants and types
`default_nettype none
package bsm_pkg;
	localparam int  BSM_ADDR_W       = 22;
	localparam logic [21:0] BSM_FLASH_ENTRY = 22'h3f7ff6;
	localparam logic [21:0] BSM_HRAM_ENTRY  = 22'h3f8000;
	localparam logic [21:0] BSM_OTP_ENTRY   = 22'h3d7800;
	localparam logic [21:0] BSM_ROM_VECTOR  = 22'h3fffc0;
	localparam logic [21:0] BSM_NO_ENTRY    = 22'h000000;
	// Cycles the init routine takes before straps are looked at
	localparam int  BSM_INIT_CYCLES  = 8;
	localparam int  BSM_CNT_W        = 4;
	localparam logic [3:0] BSM_CNT_ZERO = 4'h0;
	localparam logic [3:0] BSM_CNT_ONE  = 4'h1;
	localparam logic [3:0] BSM_CNT_LAST = 4'(BSM_INIT_CYCLES - 1);
	localparam logic [3:0] BSM_STRAP_RST = 4'h0;

	// Boot actions
	typedef enum logic [2:0] {
		BSM_MODE_NONE   = 3'h0,
		BSM_MODE_FLASH  = 3'h1,
		BSM_MODE_SPI    = 3'h2,
		BSM_MODE_UART   = 3'h3,
		BSM_MODE_HRAM   = 3'h4,
		BSM_MODE_OTP    = 3'h5,
		BSM_MODE_PAR    = 3'h6
	} bsm_mode_t;

	// Sequencer states, Gray along the path
	typedef enum logic [1:0] {
		BSM_ST_VECTOR = 2'b00,
		BSM_ST_INIT   = 2'b01,
		BSM_ST_SAMPLE = 2'b11,
		BSM_ST_DONE   = 2'b10
	} bsm_state_t;
endpackage : bsm_pkg
`default_nettype wire

// [hdl/bsm_dec_if.sv]
// Interface: strap levels to decoded mode between decoder pieces
`default_nettype none
interface bsm_dec_if;
	import bsm_pkg::*;
	logic      [3:0]  straps;
	bsm_mode_t        mode;
	logic      [21:0] entry;
	logic             loader;
	modport dec (input straps, output mode, output entry, output loader);
	modport seq (output straps, input mode, input entry, input loader);
endinterface : bsm_dec_if
`default_nettype wire

// [hdl/bsm_decode.sv]
// Combinational strap-to-mode decoder
`default_nettype none
module bsm_decode (
	bsm_dec_if.dec d
);
	import bsm_pkg::*;
	// straps[3]=pin a ... straps[0]=pin d
	always_comb begin
		d.mode   = BSM_MODE_NONE;
		d.entry  = BSM_NO_ENTRY;
		d.loader = 1'b0;
		if (d.straps[3]) begin
			d.mode  = BSM_MODE_FLASH;
			d.entry = BSM_FLASH_ENTRY;
		end else if (d.straps[2]) begin
			d.mode   = BSM_MODE_SPI;
			d.loader = 1'b1;
		end else begin
			case (d.straps[1:0])
				2'h3: begin
					d.mode   = BSM_MODE_UART;
					d.loader = 1'b1;
				end
				2'h2: begin
					d.mode  = BSM_MODE_HRAM;
					d.entry = BSM_HRAM_ENTRY;
				end
				2'h1: begin
					d.mode  = BSM_MODE_OTP;
					d.entry = BSM_OTP_ENTRY;
				end
				default: begin
					d.mode   = BSM_MODE_PAR;
					d.loader = 1'b1;
				end
			endcase
		end
	end
endmodule : bsm_decode
`default_nettype wire

// [hdl/bsm_boot_strap.sv]
// Top: boot strap mode decoder sequencer
// Function
// - Reset vector from ROM, then init routine
// - After init, sample four straps, pick mode
// - Pin a high: jump to flash entry
// - a low, b high: serial EEPROM loader
// - 0,0,1,1: UART loader on port one
// - 0,0,1,0: jump to high RAM entry
// - 0,0,0,1: jump to OTP entry
// - All low: parallel loader via port two
// - Pin a pulled up; others not
// - Direct jumps load no external code
`default_nettype none
module bsm_boot_strap (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_b,
	// Strap pins (a shared with serial tx)
	input  wire logic              strap_pin_a,
	input  wire logic              strap_pin_b,
	input  wire logic              strap_pin_c,
	input  wire logic              strap_pin_d,
	output logic                   strap_pin_a_pullup_en,
	// Boot progress
	output logic [21:0]            fetch_addr,
	output logic                   in_init_routine,
	output logic                   mode_valid,
	// Decoded result
	output bsm_pkg::bsm_mode_t     boot_mode,
	output logic [21:0]            entry_addr,
	output logic                   run_loader,
	output logic                   load_external
);
	import bsm_pkg::*;

	// Carries the captured levels to the decoder and its answer back
	bsm_dec_if dif ();

	// Sequencer
	bsm_state_t        state_reg,  state_next;

	// Init routine cycle counter
	logic [3:0]        cnt_reg,    cnt_next;

	// Captured strap levels, pin a in the top bit
	logic [3:0]        strap_reg,  strap_next;
	// Live pin levels in the same packing
	logic [3:0]        strap_live;

	// Decoded result
	bsm_mode_t         mode_reg,   mode_next;
	logic [21:0]       entry_reg,  entry_next;
	logic              loader_reg, loader_next;

	// Address the core fetches from
	logic [21:0]       fetch_reg,  fetch_next;

	// One-cycle steps of the sequence
	logic              leave_vector;
	logic              init_over;
	logic              sample_now;
	logic              latch_now;

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer: vector fetch, init routine, one strap sample, then done.
	// Done is a dead end on purpose: only a reset starts a new capture.
	// A state code off the path falls back to the vector fetch.
	assign leave_vector = (state_reg == BSM_ST_VECTOR);
	assign init_over    = (state_reg == BSM_ST_INIT) && (cnt_reg == BSM_CNT_LAST);
	assign sample_now   = (state_reg == BSM_ST_SAMPLE);
	assign latch_now    = (state_reg == BSM_ST_DONE) && (mode_reg == BSM_MODE_NONE);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			BSM_ST_VECTOR: begin
				state_next = BSM_ST_INIT;
			end
			BSM_ST_INIT: begin
				// Straps are not looked at until init is over
				if (init_over) begin
					state_next = BSM_ST_SAMPLE;
				end
			end
			BSM_ST_SAMPLE: begin
				state_next = BSM_ST_DONE;
			end
			BSM_ST_DONE: begin
				state_next = BSM_ST_DONE;
			end
			default: begin
				state_next = BSM_ST_VECTOR;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= BSM_ST_VECTOR;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Init counter: restarts on every vector fetch, so a warm reset gets the
	// full init time again instead of resuming a half-run count.
	always_comb begin
		cnt_next = cnt_reg;
		if (leave_vector) begin
			cnt_next = BSM_CNT_ZERO;
		// Holds at the last value until the state moves on
		end else if ((state_reg == BSM_ST_INIT) && !init_over) begin
			cnt_next = cnt_reg + BSM_CNT_ONE;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= BSM_CNT_ZERO;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Strap capture: each pin is taken once, in the single sample state, so
	// later traffic on the shared serial pin cannot move the mode.
	assign strap_live = {strap_pin_a, strap_pin_b, strap_pin_c, strap_pin_d};

	for (genvar gi = 0; gi < $bits(strap_reg); gi++) begin : g_strap
		always_comb begin
			strap_next[gi] = strap_reg[gi];
			if (sample_now) begin
				strap_next[gi] = strap_live[gi];
			end
		end

		// Reset level is never decoded into the result: the latch waits for a sample
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				strap_reg[gi] <= BSM_STRAP_RST[gi];
			end else begin
				strap_reg[gi] <= strap_next[gi];
			end
		end
	end : g_strap

	////////////////////////////////////////////////////////////////////////////////
	// Decoder sees the captured straps only, never the live pins
	assign dif.straps = strap_reg;

	bsm_decode u_decode (
		.d (dif.dec)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decoded result: written once, in the first done cycle. NONE doubles as the
	// not-yet-latched mark, which is safe because the decoder never returns it.
	// Entry and loader flag go with the mode so the three never disagree
	always_comb begin
		mode_next   = mode_reg;
		entry_next  = entry_reg;
		loader_next = loader_reg;
		if (latch_now) begin
			mode_next   = dif.mode;
			entry_next  = dif.entry;
			loader_next = dif.loader;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg   <= BSM_MODE_NONE;
			entry_reg  <= BSM_NO_ENTRY;
			loader_reg <= 1'b0;
		end else begin
			mode_reg   <= mode_next;
			entry_reg  <= entry_next;
			loader_reg <= loader_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fetch address: vector first, then the chosen entry. Loader modes leave it
	// at zero; the loader itself decides where its code ends up.
	always_comb begin
		fetch_next = fetch_reg;
		if (leave_vector) begin
			fetch_next = BSM_ROM_VECTOR;
		end else if (latch_now) begin
			fetch_next = dif.entry;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fetch_reg <= BSM_NO_ENTRY;
		end else begin
			fetch_reg <= fetch_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Only pin a has a pull-up so an open board boots from flash; b, c and d
	// float when left open, so a board must strap them.
	assign strap_pin_a_pullup_en = 1'b1;

	// in_init_routine decodes the sequencer, mode_valid the latched mode; both are level status
	assign fetch_addr      = fetch_reg;
	assign in_init_routine = (state_reg == BSM_ST_INIT);
	assign mode_valid      = (mode_reg != BSM_MODE_NONE);

	// Result, held from the latch cycle until the next reset
	assign boot_mode       = mode_reg;
	assign entry_addr      = entry_reg;
	assign run_loader      = loader_reg;
	// A direct jump never pulls code in from outside
	assign load_external   = loader_reg;
endmodule : bsm_boot_strap
`default_nettype wire

// [verification/bsm_board.sv]
// Board strap model: jumpers on b, c, d; pin a may float
`default_nettype none
module bsm_board (
	// Control from bench
	input  wire logic       [3:0] lvl,
	input  wire logic             a_drv,
	input  wire logic             pu,
	// Strap pins
	output logic                  pa,
	output logic                  pb,
	output logic                  pc,
	output logic                  pd
);
	timeunit 1ns;
	timeprecision 1ns;
	// A floating pin a reads the pull-up level
	assign pa = a_drv ? lvl[3] : pu;
	assign pb = lvl[2];
	assign pc = lvl[1];
	assign pd = lvl[0];
endmodule // bsm_board
`default_nettype wire

// [verification/bsm_boot_strap_properties.sv]
// Checker: port properties of the boot strap decoder
`default_nettype none
module bsm_chk (
	input wire logic               mclk,
	input wire logic               rst_b,
	input wire logic               strap_pin_a,
	input wire logic               strap_pin_b,
	input wire logic               strap_pin_a_pullup_en,
	input wire logic        [21:0] fetch_addr,
	input wire logic               in_init_routine,
	input wire logic               mode_valid,
	input wire logic         [2:0] boot_mode,
	input wire logic        [21:0] entry_addr,
	input wire logic               run_loader,
	input wire logic               load_external
);
	timeunit 1ns;
	timeprecision 1ns;
	import bsm_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence s_cap; $rose(mode_valid); endsequence
	sequence s_init_end; $fell(in_init_routine); endsequence
	AST_PU: assert property (strap_pin_a_pullup_en) else $error("pullup off");
	AST_VEC: assert property ($rose(in_init_routine) |-> fetch_addr == BSM_ROM_VECTOR)
		else $error("no rom vector");
	AST_ORDER: assert property (s_init_end |-> !mode_valid ##[1:3] mode_valid)
		else $error("mode late");
	AST_FLASH: assert property (s_cap |-> (boot_mode == BSM_MODE_FLASH) ==
		$past(strap_pin_a, 2) && fetch_addr == entry_addr) else $error("flash pick");
	AST_SPI: assert property (s_cap and $past(!strap_pin_a && strap_pin_b, 2) |->
		boot_mode == BSM_MODE_SPI) else $error("spi pick");
	AST_LOADER: assert property (mode_valid |-> load_external == run_loader &&
		run_loader == (boot_mode inside {BSM_MODE_SPI, BSM_MODE_UART, BSM_MODE_PAR}))
		else $error("loader flag");
	AST_HRAM: assert property (boot_mode == BSM_MODE_HRAM |-> entry_addr == BSM_HRAM_ENTRY)
		else $error("hram entry");
	AST_HOLD: assert property (mode_valid |=> mode_valid && $stable(boot_mode) &&
		$stable(entry_addr)) else $error("mode moved");
endmodule // bsm_chk
bind bsm_boot_strap bsm_chk u_chk (.mclk, .rst_b, .strap_pin_a, .strap_pin_b,
	.strap_pin_a_pullup_en, .fetch_addr, .in_init_routine, .mode_valid, .boot_mode,
	.entry_addr, .run_loader, .load_external);
`default_nettype wire

// [verification/bsm_boot_strap_test.sv]
// Testbench: strap decode table, float, hold and warm reset cases
`default_nettype none
module bsm_boot_strap_test;
	timeunit 1ns;
	timeprecision 1ns;
	import bsm_pkg::*;
	logic mclk = 0, rst_b = 0, a_drv = 1, pa, pb, pc, pd, pu, ii, mode_valid, rl, le;
	logic [3:0] lvl = 4'h0;
	logic [21:0] fa, entry_addr;
	bsm_mode_t boot_mode;
	int failures = 0, num_checks = 0;
	// Rows: straps a,b,c,d then expected mode
	logic [6:0] rows [8] = '{{4'h8, BSM_MODE_FLASH}, {4'hf, BSM_MODE_FLASH},
		{4'h4, BSM_MODE_SPI}, {4'h7, BSM_MODE_SPI}, {4'h3, BSM_MODE_UART},
		{4'h2, BSM_MODE_HRAM}, {4'h1, BSM_MODE_OTP}, {4'h0, BSM_MODE_PAR}};
	always #50 mclk = ~mclk;
	bsm_board brd (.lvl, .a_drv, .pu, .pa, .pb, .pc, .pd);
	bsm_boot_strap uut (.mclk, .rst_b, .strap_pin_a(pa), .strap_pin_b(pb), .strap_pin_c(pc),
		.strap_pin_d(pd), .strap_pin_a_pullup_en(pu), .fetch_addr(fa), .in_init_routine(ii),
		.mode_valid, .boot_mode, .entry_addr, .run_loader(rl), .load_external(le));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [21:0] g, input logic [21:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	// Reset with straps set, then wait for the decoded mode
	task automatic boot(input logic [3:0] v);
		@(posedge mclk) #5 rst_b = 0;
		lvl = v;
		@(posedge mclk) #5 chk(mode_valid, 0);
		@(posedge mclk) #5 rst_b = 1;
		@(posedge mclk) #5 chk(fa, BSM_ROM_VECTOR);
		chk(ii, 1);
		for (int i = 0; i < 20 && mode_valid !== 1'b1; i++) @(posedge mclk) #5;
		if (mode_valid !== 1'b1) begin
			failures++;
			report_and_stop();
		end
	endtask
	function automatic logic [21:0] ent(input logic [2:0] m);
		case (m)
			BSM_MODE_FLASH: return BSM_FLASH_ENTRY;
			BSM_MODE_HRAM: return BSM_HRAM_ENTRY;
			BSM_MODE_OTP: return BSM_OTP_ENTRY;
			default: return BSM_NO_ENTRY;
		endcase
	endfunction
	initial begin
		#20 chk(pu, 1);
		foreach (rows[i]) begin
			boot(rows[i][6:3]);
			chk(boot_mode, rows[i][2:0]);
			chk(entry_addr, ent(rows[i][2:0]));
			chk(fa, ent(rows[i][2:0]));
			chk(le, rows[i][2:0] inside {BSM_MODE_SPI, BSM_MODE_UART, BSM_MODE_PAR});
			chk(rl, rows[i][2:0] inside {BSM_MODE_SPI, BSM_MODE_UART, BSM_MODE_PAR});
			$display("row %0d done", i);
		end
		lvl = 4'hf;
		repeat (3) @(posedge mclk);
		#5 chk(boot_mode, BSM_MODE_PAR);
		$display("hold test done");
		a_drv = 0;
		boot(4'h0);
		chk(boot_mode, BSM_MODE_FLASH);
		a_drv = 1;
		$display("float test done");
		@(posedge mclk) #5 rst_b = 0;
		@(posedge mclk) #5 rst_b = 1;
		repeat (4) @(posedge mclk);
		#5 chk(ii, 1);
		chk(mode_valid, 0);
		boot(4'h2);
		chk(boot_mode, BSM_MODE_HRAM);
		$display("warm reset test done");
		report_and_stop();
	end
endmodule // bsm_boot_strap_test
`default_nettype wire
